// ---- src/tracking_delay_adc_control_regs.sv ----
// APB register bank for slot masking, reference converter control,
// audio output delay and input converter conditioning
// assumes an APB master on pclk; data ports come from logic on pclk
//
// Notes on behaviour
// - mask bits 7..0 gate second input slots 9..16
// - all ones masks all; result ORs with others
// - tracking mode polarity moves reference to full scale
// - otherwise polarity bit inverts reference output
// - offset code adds three percent steps
// - polarity and gain set doubles offset
// - delay code adds up to 500 microseconds
// - delay given as whole samples per rate
// - supply select bit matches analog supply level
// - filter enable bit applies input high-pass
// - invert bits negate each input channel
// - filter select code ten means tracking mode
// - masks used only when source select is 100
`timescale 1ns/1ns
`include "track_regs_params.svh"

module tracking_delay_adc_control_regs
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output      logic [31:0]          prdata,
   output      logic                 pready,
   output      logic                 pslverr,
   output      logic [7:0]           slot_track_en,
   output      logic                 ref_tracking_mode,
   output      logic                 ref_full_scale_ref,
   output      logic                 ref_invert,
   output      logic [5:0]           ref_offset_percent,
   output      logic [3:0]           delay_code,
   output      track_regs_pkg::sample_count_t delay_samples,
   output      logic                 supply_5v_select,
   output      logic                 input_highpass_enable,
   input  wire logic                 conv_in_valid,
   input  wire logic [95:0]          conv_in_data,
   output      logic                 conv_out_valid,
   output      logic [95:0]          conv_out_data
);

   // samples of added delay, one row per delay code, 8 bits per rate, 32 kHz lowest
   localparam logic [47:0] DELAY_TABLE [0:15] = '{
      48'h000000000000, 48'h0A0906050403, 48'h0E0D0A070705, 48'h13120D0A0906,
      48'h16140E0B0A07, 48'h1816100C0B08, 48'h1A18120D0C09, 48'h1D1B130E0D0A,
      48'h1F1D150F0E0A, 48'h221F16110F0B, 48'h24211812100C, 48'h26241A13110D,
      48'h29261B14120E, 48'h2B281D15140F, 48'h2E2A1E17150F, 48'h302C20181610
   };

   logic [7:0]  upper_slot_track_mask_q;
   logic [7:0]  tracking_supply_control_q;
   logic [7:0]  input_converter_control_one_q;
   logic [8:0]  reference_path_config_q;
   logic [31:0] prdata_q;
   logic [7:0]  slot_track_en_q;
   logic        ref_tracking_mode_q;
   logic        ref_full_scale_ref_q;
   logic        ref_invert_q;
   logic [5:0]  ref_offset_percent_q;
   logic [5:0]  delay_samples_q;
   logic        conv_out_valid_q;

   // bus decode
   wire         addr_ok   = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
   wire  [7:0]  addr_idx  = paddr[9:2];
   wire         sel_mask  = addr_ok && (addr_idx == `IDX_UPPER_MASK);
   wire         sel_track = addr_ok && (addr_idx == `IDX_TRACK_CTRL);
   wire         sel_inc   = addr_ok && (addr_idx == `IDX_INCONV_CTRL);
   wire         sel_cfg   = addr_ok && (addr_idx == `IDX_REF_CFG);
   wire         sel_stat  = addr_ok && (addr_idx == `IDX_STATUS);
   wire         addr_hit  = sel_mask || sel_track || sel_inc || sel_cfg || sel_stat;
   wire         setup_ph  = psel && !penable;
   wire         access_ph = psel && penable;
   wire         wr_en     = access_ph && pwrite && addr_hit;
   wire         wr_lane0  = wr_en && pstrb[0];
   wire         wr_lane1  = wr_en && pstrb[1];

   // field views
   wire         pol_bit   = tracking_supply_control_q[`POL_BIT];
   wire  [2:0]  ofs_code  = tracking_supply_control_q[`OFS_MSB:`OFS_LSB];
   wire  [3:0]  dly_code  = tracking_supply_control_q[`DLY_MSB:`DLY_LSB];
   wire  [1:0]  flt_sel   = reference_path_config_q[`CFG_FLT_MSB:`CFG_FLT_LSB];
   wire  [2:0]  src_sel   = reference_path_config_q[`CFG_SRC_MSB:`CFG_SRC_LSB];
   wire         gain_sel  = reference_path_config_q[`CFG_GAIN_BIT];
   wire  [2:0]  rate_sel  = reference_path_config_q[`CFG_RATE_MSB:`CFG_RATE_LSB];
   wire         trk_mode  = (flt_sel == track_regs_pkg::REF_TRACKING);
   wire         mask_src  = (src_sel == `SRC_MASK_SEL);

   // slot i of the output is slot 9+i; mask bit order descends
   wire  [7:0]  slot_en_d;
   // reversed view lines slot order up with mask bit order for checking
   wire  [7:0]  slot_en_rev;
   genvar s;
   generate
      for (s = 0; s < 8; s++)
      begin : g_slot
         assign slot_en_d[s] = mask_src && !upper_slot_track_mask_q[7 - s];
         assign slot_en_rev[s] = slot_track_en_q[7 - s];
      end
   endgenerate

   // doubling only when polarity and gain are both set
   wire  [5:0]  ofs_base  = 6'({3'h0, ofs_code} * `OFS_STEP_PCT);
   wire  [5:0]  ofs_d     = (pol_bit && gain_sel) ? 6'(ofs_base << 1) : ofs_base;

   // rate codes above the table read as no delay
   wire  [47:0] dly_row   = DELAY_TABLE[dly_code];
   wire  [5:0]  dly_d     = (rate_sel > 3'h5) ? 6'h00 : dly_row[{rate_sel, 3'h0} +: 6];

   wire  [31:0] status_w  = {20'h00000, 2'h0, delay_samples_q, trk_mode, mask_src,
                             ref_invert_q, ref_full_scale_ref_q};
   wire  [31:0] rd_mux    = sel_mask  ? {24'h000000, upper_slot_track_mask_q} :
                            sel_track ? {24'h000000, tracking_supply_control_q} :
                            sel_inc   ? {24'h000000, input_converter_control_one_q} :
                            sel_cfg   ? {23'h0, reference_path_config_q} :
                            sel_stat  ? status_w : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         upper_slot_track_mask_q <= `RST_UPPER_MASK;
         tracking_supply_control_q <= `RST_TRACK_CTRL;
         input_converter_control_one_q <= `RST_INCONV_CTRL;
      end
      else
      begin
         if (wr_lane0 && sel_mask)
            upper_slot_track_mask_q <= pwdata[7:0];
         // the delay takes effect at once; software keeps converters idle meanwhile
         if (wr_lane0 && sel_track)
            tracking_supply_control_q <= pwdata[7:0];
         if (wr_lane0 && sel_inc)
            input_converter_control_one_q <= pwdata[7:0] & `INCONV_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reference_path_config_q <= `RST_REF_CFG;
      else
      begin
         if (wr_lane0 && sel_cfg)
            reference_path_config_q[7:0] <= pwdata[7:0];
         if (wr_lane1 && sel_cfg)
            reference_path_config_q[8] <= pwdata[8];
      end
   end

   // read data is captured in the setup cycle so the answer comes from a flop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h00000000;
      else if (setup_ph && !pwrite)
         prdata_q <= rd_mux;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot_track_en_q <= 8'h00;
         ref_tracking_mode_q <= 1'b0;
         ref_full_scale_ref_q <= 1'b0;
         ref_invert_q <= 1'b0;
         ref_offset_percent_q <= 6'h00;
         delay_samples_q <= 6'h00;
      end
      else
      begin
         slot_track_en_q <= slot_en_d;
         ref_tracking_mode_q <= trk_mode;
         ref_full_scale_ref_q <= pol_bit && trk_mode;
         ref_invert_q <= pol_bit && !trk_mode;
         ref_offset_percent_q <= ofs_d;
         delay_samples_q <= dly_d;
      end
   end

   // input conditioning: first-order DC blocker, then optional negation
   genvar c;
   generate
      for (c = 0; c < 4; c++)
      begin : g_chan
         logic signed [25:0] x1_q;
         logic signed [25:0] y1_q;
         logic        [23:0] out_q;
         wire  signed [25:0] x_w   = 26'(signed'(conv_in_data[c*24 +: 24]));
         wire  signed [25:0] y_w   = 26'(x_w - x1_q + y1_q - (y1_q >>> `HPF_SHIFT));
         wire                hpf_w = input_converter_control_one_q[`HPF_BIT];
         wire                inv_w = input_converter_control_one_q[c];
         wire         [23:0] pre_w = hpf_w ? y_w[23:0] : x_w[23:0];
         wire         [23:0] fin_w = inv_w ? 24'(-pre_w) : pre_w;

         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               x1_q <= 26'h0;
               y1_q <= 26'h0;
               out_q <= 24'h000000;
            end
            else if (conv_in_valid)
            begin
               x1_q <= x_w;
               y1_q <= hpf_w ? y_w : 26'h0;
               out_q <= fin_w;
            end
         end

         assign conv_out_data[c*24 +: 24] = out_q;
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         conv_out_valid_q <= 1'b0;
      else
         conv_out_valid_q <= conv_in_valid;
   end

   assign prdata                = prdata_q;
   assign pready                = 1'b1;
   assign pslverr               = access_ph && !addr_hit;
   assign slot_track_en         = slot_track_en_q;
   assign ref_tracking_mode     = ref_tracking_mode_q;
   assign ref_full_scale_ref    = ref_full_scale_ref_q;
   assign ref_invert            = ref_invert_q;
   assign ref_offset_percent    = ref_offset_percent_q;
   assign delay_code            = dly_code;
   assign delay_samples         = delay_samples_q;
   // the device scales its internal levels from this bit
   assign supply_5v_select      = input_converter_control_one_q[`SUP_BIT];
   assign input_highpass_enable = input_converter_control_one_q[`HPF_BIT];
   assign conv_out_valid        = conv_out_valid_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence mask_write_s;
      wr_lane0 && sel_mask;
   endsequence

   sequence track_write_s;
      wr_lane0 && sel_track;
   endsequence

   sequence inconv_write_s;
      wr_lane0 && sel_inc;
   endsequence

   AST_SLOT_FROM_MASK: assert property (
      mask_write_s ##1 (mask_src && !wr_en) |=>
         slot_en_rev == ~$past(pwdata[7:0], 2))
      else $error("slot enables do not follow mask write");

   AST_SLOT16_BIT0: assert property (
      mask_src && !upper_slot_track_mask_q[0] |=> slot_track_en[7])
      else $error("slot 16 not enabled by clear bit 0");

   AST_ALL_MASKED: assert property (
      (upper_slot_track_mask_q == 8'hFF) [*2] |-> slot_track_en == 8'h00)
      else $error("slot enabled while all masked");

   AST_SOURCE_GATE: assert property (
      !mask_src [*2] |-> slot_track_en == 8'h00)
      else $error("mask used without mask source");

   AST_FULL_SCALE: assert property (
      track_write_s ##0 pwdata[7] ##1 (trk_mode && !wr_en) |=>
         ref_full_scale_ref && !ref_invert)
      else $error("tracking polarity not full scale");

   AST_INVERT_REF: assert property (
      track_write_s ##0 pwdata[7] ##1 (!trk_mode && !wr_en) |=>
         ref_invert && !ref_full_scale_ref)
      else $error("polarity bit did not invert reference");

   AST_OFFSET: assert property (
      track_write_s ##0 !pwdata[7] ##1 !wr_en |=>
         ref_offset_percent == 6'($past(pwdata[6:4], 2) * 3))
      else $error("offset step wrong");

   AST_OFFSET_DOUBLE: assert property (
      $past(pol_bit && gain_sel) |-> ref_offset_percent == 6'($past(ofs_code) * 6))
      else $error("offset not doubled");

   AST_DELAY_MAX: assert property (
      $past(dly_code == 4'hF) && $past(rate_sel == 3'h0) |-> delay_samples == 6'h10 ##0
      1'b1)
      else $error("delay at 32 kHz wrong");

   AST_DELAY_MAX_96: assert property (
      $past(dly_code == 4'hF) && $past(rate_sel == 3'h5) |-> delay_samples == 6'h30)
      else $error("delay at 96 kHz wrong");

   AST_INVERT_IN: assert property (
      conv_in_valid && !input_highpass_enable && input_converter_control_one_q[0] |=>
         conv_out_data[23:0] == 24'(-$past(conv_in_data[23:0])))
      else $error("input channel not inverted");

   AST_HPF_BYPASS: assert property (
      conv_in_valid && !input_highpass_enable && !input_converter_control_one_q[1] |=>
         conv_out_data[47:24] == $past(conv_in_data[47:24]))
      else $error("bypass altered input data");

   AST_RESERVED: assert property (
      input_converter_control_one_q[7:6] == 2'h0)
      else $error("reserved input control bits set");

   AST_SUPPLY_SEL: assert property (
      inconv_write_s |=> supply_5v_select == $past(pwdata[`SUP_BIT]))
      else $error("supply select does not follow write");

   AST_HPF_ENABLE: assert property (
      inconv_write_s |=> input_highpass_enable == $past(pwdata[`HPF_BIT]))
      else $error("high-pass enable does not follow write");

   AST_TRACK_MODE: assert property (
      ref_tracking_mode == ($past(flt_sel) == 2'b10))
      else $error("tracking mode flag wrong");

   AST_POL_EXCLUSIVE: assert property (
      !(ref_full_scale_ref && ref_invert))
      else $error("reference both inverted and full scale");

   AST_DELAY_CODE: assert property (
      track_write_s |=> delay_code == $past(pwdata[3:0]))
      else $error("delay code does not follow write");

   AST_DELAY_NONE: assert property (
      $past(dly_code == 4'h0) |-> delay_samples == 6'h00)
      else $error("delay added at code zero");

endmodule

// ---- src/track_regs_params.svh ----
// constants for the tracking, delay and input converter control bank
// assumes byte addressing on a 12-bit APB address, one 32-bit word per register
`ifndef TRACK_REGS_PARAMS_SVH
`define TRACK_REGS_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_UPPER_MASK  8'h0D
`define IDX_TRACK_CTRL  8'h0E
`define IDX_INCONV_CTRL 8'h0F
`define IDX_REF_CFG     8'h20
`define IDX_STATUS      8'h21

// reset values
`define RST_UPPER_MASK  8'hFF
`define RST_TRACK_CTRL  8'h00
`define RST_INCONV_CTRL 8'h00
`define RST_REF_CFG     9'h000

// tracking control fields
`define POL_BIT         7
`define OFS_MSB         6
`define OFS_LSB         4
`define DLY_MSB         3
`define DLY_LSB         0

// input converter control fields
`define SUP_BIT         5
`define HPF_BIT         4
`define INV_MSB         3
`define INCONV_WMASK    8'h3F

// reference path configuration fields
`define CFG_FLT_MSB     1
`define CFG_FLT_LSB     0
`define CFG_SRC_MSB     4
`define CFG_SRC_LSB     2
`define CFG_GAIN_BIT    5
`define CFG_RATE_MSB    8
`define CFG_RATE_LSB    6

// codes and steps
`define SRC_MASK_SEL    3'h4
`define OFS_STEP_PCT    6'h03
`define HPF_SHIFT       10

`endif

// ---- src/track_regs_pkg.sv ----
// types shared by the tracking, delay and input converter control bank
// assumes the constants header is included by the design file
package track_regs_pkg;

   typedef enum logic [1:0] {
      REF_INTERP      = 2'b00,
      REF_SAMPLE_HOLD = 2'b01,
      REF_TRACKING    = 2'b10,
      REF_RESERVED    = 2'b11
   } ref_filter_t;

   typedef enum logic [2:0] {
      RATE_32K  = 3'b000,
      RATE_44K1 = 3'b001,
      RATE_48K  = 3'b010,
      RATE_64K  = 3'b011,
      RATE_88K2 = 3'b100,
      RATE_96K  = 3'b101
   } sample_rate_t;

   typedef logic [5:0] sample_count_t;

endpackage

// ---- dv/tracking_delay_adc_control_regs_bench.sv ----
// self-checking bench for the tracking, delay and input converter control bank
// assumes the constants header is on the include path and APB with zero wait states
`timescale 1ns/1ns
`include "track_regs_params.svh"

module tracking_delay_adc_control_regs_bench;
   logic                          pclk;
   logic                          presetn;
   logic                          psel;
   logic                          penable;
   logic                          pwrite;
   logic [11:0]                   paddr;
   logic [31:0]                   pwdata;
   logic [3:0]                    pstrb;
   logic [31:0]                   prdata;
   logic                          pready;
   logic                          pslverr;
   logic [7:0]                    slot_track_en;
   logic                          ref_tracking_mode;
   logic                          ref_full_scale_ref;
   logic                          ref_invert;
   logic [5:0]                    ref_offset_percent;
   logic [3:0]                    delay_code;
   track_regs_pkg::sample_count_t delay_samples;
   logic                          supply_5v_select;
   logic                          input_highpass_enable;
   logic                          conv_in_valid;
   logic [95:0]                   conv_in_data;
   logic                          conv_out_valid;
   logic [95:0]                   conv_out_data;
   int                            err_count;
   int                            n_checks;

   tracking_delay_adc_control_regs u_tracking_delay_adc_control_regs
   (
      .pclk                  (pclk),
      .presetn               (presetn),
      .psel                  (psel),
      .penable               (penable),
      .pwrite                (pwrite),
      .paddr                 (paddr),
      .pwdata                (pwdata),
      .pstrb                 (pstrb),
      .prdata                (prdata),
      .pready                (pready),
      .pslverr               (pslverr),
      .slot_track_en         (slot_track_en),
      .ref_tracking_mode     (ref_tracking_mode),
      .ref_full_scale_ref    (ref_full_scale_ref),
      .ref_invert            (ref_invert),
      .ref_offset_percent    (ref_offset_percent),
      .delay_code            (delay_code),
      .delay_samples         (delay_samples),
      .supply_5v_select      (supply_5v_select),
      .input_highpass_enable (input_highpass_enable),
      .conv_in_valid         (conv_in_valid),
      .conv_in_data          (conv_in_data),
      .conv_out_valid        (conv_out_valid),
      .conv_out_data         (conv_out_data)
   );

   always #5 pclk = ~pclk;

   task automatic test_done;
      if (err_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // request held from setup until pready is sampled high in the access phase
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      logic        e;
      apb(1'b1, idx, d, s, r, e);
      chk("write pslverr", e, 1'b0);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] r);
      logic e;
      apb(1'b0, idx, 32'h0, 4'h0, r, e);
      chk("read pslverr", e, 1'b0);
   endtask

   // derived outputs follow a register one edge later
   task automatic settle;
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task automatic t_reset;
      logic [31:0] r;
      logic        e;
      settle();
      chk("slot_track_en reset", slot_track_en, 8'h00);
      chk("pready reset", pready, 1'b1);
      chk("delay_samples reset", delay_samples, 6'h00);
      chk("ref_offset_percent reset", ref_offset_percent, 6'h00);
      chk("supply_5v_select reset", supply_5v_select, 1'b0);
      chk("highpass reset", input_highpass_enable, 1'b0);
      rd(`IDX_UPPER_MASK, r);
      chk("mask reset", r, 32'h0000_00FF);
      rd(`IDX_TRACK_CTRL, r);
      chk("track ctrl reset", r, 32'h0000_0000);
      rd(`IDX_INCONV_CTRL, r);
      chk("input ctrl reset", r, 32'h0000_0000);
      apb(1'b1, 8'h10, 32'h0000_0000, 4'hF, r, e);
      chk("unmapped write pslverr", e, 1'b1);
      apb(1'b0, 8'h10, 32'h0000_0000, 4'h0, r, e);
      chk("unmapped read pslverr", e, 1'b1);
      chk("unmapped read data", r, 32'h0000_0000);
   endtask

   task automatic t_mask;
      logic [7:0]  masks[5] = '{8'hFF, 8'h7F, 8'hFE, 8'h00, 8'hA5};
      logic [7:0]  exp;
      logic [31:0] r;
      wr(`IDX_REF_CFG, 32'h0000_0010, 4'h1);
      foreach (masks[k])
      begin
         wr(`IDX_UPPER_MASK, {24'h0, masks[k]}, 4'h1);
         settle();
         for (int i = 0; i < 8; i++)
            exp[i] = ~masks[k][7 - i];
         chk("slot_track_en", slot_track_en, exp);
         rd(`IDX_UPPER_MASK, r);
         chk("mask readback", r, {24'h0, masks[k]});
      end
      wr(`IDX_REF_CFG, 32'h0000_0000, 4'h1);
      settle();
      chk("slot_track_en source off", slot_track_en, 8'h00);
   endtask

   task automatic t_ref;
      for (int f = 0; f < 4; f++)
         for (int p = 0; p < 2; p++)
            for (int g = 0; g < 2; g++)
               for (int c = 0; c < 8; c++)
               begin
                  wr(`IDX_TRACK_CTRL, {24'h0, p[0], c[2:0], 4'h0}, 4'h1);
                  wr(`IDX_REF_CFG, {26'h0, g[0], 3'b000, f[1:0]}, 4'h1);
                  settle();
                  chk("ref_tracking_mode", ref_tracking_mode, f == 2);
                  chk("ref_full_scale_ref", ref_full_scale_ref, p == 1 && f == 2);
                  chk("ref_invert", ref_invert, p == 1 && f != 2);
                  chk("ref_offset_percent", ref_offset_percent,
                      c * ((p == 1 && g == 1) ? 6 : 3));
               end
   endtask

   task automatic t_delay;
      // code, rate select, samples
      logic [12:0] tbl[8] = '{{4'hF, 3'h0, 6'h10}, {4'hF, 3'h2, 6'h18}, {4'hF, 3'h5, 6'h30},
                              {4'h1, 3'h0, 6'h03}, {4'h7, 3'h4, 6'h1B}, {4'h8, 3'h3, 6'h15},
                              {4'h0, 3'h5, 6'h00}, {4'hF, 3'h6, 6'h00}};
      logic [31:0] r;
      // converter traffic stays idle while the delay code moves
      foreach (tbl[k])
      begin
         wr(`IDX_REF_CFG, {23'h0, tbl[k][8:6], 6'h00}, 4'h3);
         wr(`IDX_TRACK_CTRL, {28'h0, tbl[k][12:9]}, 4'h1);
         settle();
         chk("delay_code", delay_code, tbl[k][12:9]);
         chk("delay_samples", delay_samples, tbl[k][5:0]);
         rd(`IDX_STATUS, r);
         chk("status delay", r[9:4], tbl[k][5:0]);
      end
      wr(`IDX_STATUS, 32'h0000_03FF, 4'hF);
      rd(`IDX_STATUS, r);
      chk("status after write", r[9:4], 6'h00);
   endtask

   task automatic t_input;
      logic [31:0] r;
      wr(`IDX_INCONV_CTRL, 32'h0000_00FF, 4'h1);
      settle();
      rd(`IDX_INCONV_CTRL, r);
      chk("input ctrl readback", r, 32'h0000_003F);
      chk("supply_5v_select on", supply_5v_select, 1'b1);
      chk("highpass on", input_highpass_enable, 1'b1);
      wr(`IDX_INCONV_CTRL, 32'h0000_0025, 4'h1);
      settle();
      chk("highpass off", input_highpass_enable, 1'b0);
      @(posedge pclk);
      conv_in_valid <= 1'b1;
      conv_in_data  <= {24'h0ABCDE, 24'h800001, 24'h123456, 24'h000100};
      @(posedge pclk);
      conv_in_valid <= 1'b0;
      #1;
      chk("conv_out_valid", conv_out_valid, 1'b1);
      chk("conv_out_data", conv_out_data,
          {24'h0ABCDE, 24'h7FFFFF, 24'h123456, 24'hFFFF00});
      @(posedge pclk);
      #1;
      chk("conv_out_valid low", conv_out_valid, 1'b0);
      wr(`IDX_INCONV_CTRL, 32'h0000_0010, 4'h1);
      settle();
      chk("supply_5v_select off", supply_5v_select, 1'b0);
      chk("highpass on again", input_highpass_enable, 1'b1);
      // same samples again with the filter on: a held level is blocked
      @(posedge pclk);
      conv_in_valid <= 1'b1;
      @(posedge pclk);
      conv_in_valid <= 1'b0;
      #1;
      chk("conv_out_data highpass", conv_out_data, 96'h0);
   endtask

   initial
   begin
      pclk          = 1'b0;
      presetn       = 1'b0;
      psel          = 1'b0;
      penable       = 1'b0;
      pwrite        = 1'b0;
      paddr         = 12'h000;
      pwdata        = 32'h0000_0000;
      pstrb         = 4'h0;
      conv_in_valid = 1'b0;
      conv_in_data  = 96'h0;
      err_count     = 0;
      n_checks      = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_mask();
      t_ref();
      t_delay();
      t_input();
      test_done();
   end

   // the whole sequence needs about 1230 cycles; this allows a wide margin
   initial
   begin
      #300000;
      err_count++;
      test_done();
   end
endmodule
